//--- common/cfg_pkg.sv
// ==========================================================
// Configuration loader constants
`default_nettype none
package cfg_pkg;

  // ==========================================================
  // Clocking
  localparam int unsigned CLK_HZ           = 20_000_000;
  localparam int unsigned CLK_MHZ          = CLK_HZ / 1_000_000;
  localparam int unsigned BOOT_HZ          = 2_500_000;
  // Boot divider, rounded up so the boot rate is never exceeded
  localparam int unsigned BOOT_PERIOD      = (CLK_HZ + BOOT_HZ - 1) / BOOT_HZ;
  localparam int unsigned DEFAULT_RATE_MHZ = 4;
  localparam int unsigned MAX_RATE_MHZ     = 60;
  // Fastest divider the system clock allows
  localparam int unsigned MIN_PERIOD       = 2;
  localparam int unsigned PERIOD_W         = 4;

  // ==========================================================
  // Sequencing
  localparam int unsigned CLEAR_CYCLES     = 16;
  localparam int unsigned ABORT_EDGES      = 4;
  // Straps read once the synchronisers have refilled after reset
  localparam int unsigned MODE_CAPTURE     = 2;
  localparam int unsigned FIFO_DEPTH       = 16;
  localparam logic [31:0] SYNC_WORD        = 32'hA5C3_5AF0;

  // ==========================================================
  // Load modes
  typedef enum logic [1:0] {
    MODE_MASTER = 2'b00,
    MODE_SCAN   = 2'b01,
    MODE_BYTE   = 2'b10,
    MODE_SLAVE  = 2'b11
  } mode_e;

endpackage
`default_nettype wire

//--- core/cfg_sync.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Two-stage synchroniser
module cfg_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;

  sync_s st_q;
  sync_s st_d;

  always_comb
  begin
    st_d    = st_q;
    st_d.s1 = async_i;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign sync_o = st_q.s2;

endmodule
`default_nettype wire

//--- core/cfg_fifo.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Byte FIFO between the load ports and the internal bus
module cfg_fifo #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0]             wr;
    logic [AW:0]             rd;
  } fifo_s;

  fifo_s st_q;
  fifo_s st_d;
  logic  full;
  logic  empty;

  // Extra pointer bit tells full from empty
  assign empty     = (st_q.wr == st_q.rd);
  assign full      = (st_q.wr[AW-1:0] == st_q.rd[AW-1:0]) && (st_q.wr[AW] != st_q.rd[AW]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = st_q.mem[st_q.rd[AW-1:0]];

  always_comb
  begin
    st_d = st_q;
    if (in_valid && !full)
    begin
      st_d.mem[st_q.wr[AW-1:0]] = in_data;
      st_d.wr                   = st_q.wr + 1'b1;
    end
    if (out_ready && !empty)
      st_d.rd = st_q.rd + 1'b1;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

endmodule
`default_nettype wire

//--- core/config_port_loader.sv
// Functional notes
// - Master serial samples data on generated rising edge
// - After load, forward serial data to chain output
// - Generated clock starts slow, only speeds up
// - Boot at 2.5 MHz, option default 4 MHz
// - Selected generated rate never above 60 MHz
// - Mode pins 000 or 100 select master serial
// - Mode pins 101 or 001 select scan only
// - Source holds byte while busy is high
// - Byte taken at edge only when busy low
// - Busy rises only on stall or abort
// - Select with write strobe high drives readback
// - Bus line 0 carries byte MSB
// - Packets may span several select assertions
// - Direction change aborts, busy held until done
// - After abort ignore data until sync word
// - Write strobe released under select starts abort
// - Load instruction turns scan bits into bytes
// - Scan loading works in every mode
// - Byte port released or kept after configuration
// - Flag clear complete and configuration complete
`timescale 1ns/10ps
`default_nettype none
module config_port_loader #(
  parameter logic [31:0] SYNC_WORD = cfg_pkg::SYNC_WORD,
  parameter int unsigned DEPTH     = cfg_pkg::FIFO_DEPTH
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [2:0] mode_pins,
  input  wire logic       din,
  output logic            dout,
  input  wire logic       cfg_clock_i,
  output logic            cfg_clock_o,
  output logic            cfg_clock_oe_n,
  input  wire logic       cs_n,
  input  wire logic       write_n,
  input  wire logic [7:0] data_i,
  output logic      [7:0] data_o,
  output logic            data_oe_n,
  output logic            busy,
  input  wire logic       jtag_tck,
  input  wire logic       jtag_tdi,
  input  wire logic       jtag_shift_dr,
  input  wire logic       cfg_load_instr,
  input  wire logic [5:0] rate_opt_mhz,
  input  wire logic       rate_opt_load,
  input  wire logic       retain_port,
  input  wire logic       load_complete,
  input  wire logic [7:0] rb_data,
  input  wire logic       rb_valid,
  output logic            rb_ready,
  output logic      [7:0] cfg_bus_data,
  output logic            cfg_bus_valid,
  input  wire logic       cfg_bus_ready,
  output logic            init_done,
  output logic            cfg_done
);

  // ==========================================================
  // Helpers
  function automatic logic [7:0] bitrev(input logic [7:0] b);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++)
      r[i] = b[7-i];
    return r;
  endfunction

  function automatic cfg_pkg::mode_e mode_decode(input logic [2:0] m);
    cfg_pkg::mode_e r;
    unique case (m[1:0])
      2'b00: r = cfg_pkg::MODE_MASTER;
      2'b01: r = cfg_pkg::MODE_SCAN;
      2'b10: r = cfg_pkg::MODE_BYTE;
      2'b11: r = cfg_pkg::MODE_SLAVE;
    endcase
    return r;
  endfunction

  // Smallest divider whose rate does not exceed the request, or 15 if none does
  function automatic logic [cfg_pkg::PERIOD_W-1:0] rate_period(input logic [5:0] mhz);
    logic [cfg_pkg::PERIOD_W-1:0] p;
    p = 4'hF;
    for (int i = 15; i >= int'(cfg_pkg::MIN_PERIOD); i--)
      if (i * int'(mhz) >= int'(cfg_pkg::CLK_MHZ))
        p = 4'(i);
    return p;
  endfunction

  // ==========================================================
  // Pin synchronisers
  logic [18:0] sync_q;
  logic [2:0]  mode_s;
  logic        din_s;
  logic        lclk_s;
  logic        cs_n_s;
  logic        write_n_s;
  logic [7:0]  data_s;
  logic        tck_s;
  logic        tdi_s;
  logic        sdr_s;
  logic        instr_s;

  cfg_sync #(
    .W (19)
  ) u_sync (
    .clk     (clk),
    .arst_n  (arst_n),
    .async_i ({mode_pins, din, cfg_clock_i, cs_n, write_n, data_i,
               jtag_tck, jtag_tdi, jtag_shift_dr, cfg_load_instr}),
    .sync_o  (sync_q)
  );

  assign {mode_s, din_s, lclk_s, cs_n_s, write_n_s, data_s, tck_s, tdi_s, sdr_s, instr_s} = sync_q;

  // ==========================================================
  // State
  typedef struct packed {
    cfg_pkg::mode_e               mode;
    logic                         mode_seen;
    logic [7:0]                   clr_cnt;
    logic                         init_done;
    logic                         done;
    logic [cfg_pkg::PERIOD_W-1:0] period;
    logic [cfg_pkg::PERIOD_W-1:0] div_cnt;
    logic                         rate_loaded;
    logic                         cfg_clock;
    logic [2:0]                   bit_cnt;
    logic [7:0]                   shreg;
    logic                         dout;
    logic                         lclk;
    logic                         tck;
    logic                         cs_prev;
    logic                         wr_prev;
    logic                         busy;
    logic [2:0]                   abort_cnt;
    logic                         aligned;
    logic [31:0]                  sync_sh;
    logic [7:0]                   rd;
    logic                         rb_take;
    logic                         push;
    logic [7:0]                   push_data;
  } loader_s;

  loader_s st_q;
  loader_s st_d;
  logic    fifo_in_ready;
  logic    room;
  logic    ms_rise;
  logic    link_rise;
  logic    tck_rise;
  logic    port_en;
  logic    cs_act;
  logic    wr_act;

  // Leave a slot free while a push is still in flight
  assign room      = fifo_in_ready && !st_q.push;
  assign ms_rise   = (st_q.mode == cfg_pkg::MODE_MASTER) && st_q.init_done && room &&
                     (st_q.div_cnt >= st_q.period - 1'b1);
  assign link_rise = lclk_s && !st_q.lclk;
  assign tck_rise  = tck_s && !st_q.tck;
  assign port_en   = (st_q.mode == cfg_pkg::MODE_BYTE) && st_q.init_done &&
                     (!st_q.done || retain_port);
  assign cs_act    = !cs_n_s;
  assign wr_act    = !write_n_s;

  always_comb
  begin
    st_d         = st_q;
    st_d.push    = 1'b0;
    st_d.rb_take = 1'b0;
    st_d.lclk    = lclk_s;
    st_d.tck     = tck_s;

    // ==========================================================
    // Mode capture and clearing phase
    if (!st_q.mode_seen && (st_q.clr_cnt == 8'(cfg_pkg::MODE_CAPTURE)))
    begin
      st_d.mode      = mode_decode(mode_s);
      st_d.mode_seen = 1'b1;
    end
    if (!st_q.init_done)
    begin
      st_d.clr_cnt = st_q.clr_cnt + 8'h01;
      if (st_q.clr_cnt == 8'(cfg_pkg::CLEAR_CYCLES - 1))
        st_d.init_done = 1'b1;
    end
    if (load_complete && st_q.init_done)
      st_d.done = 1'b1;

    // ==========================================================
    // Generated clock; only ever moves to a shorter period
    if (rate_opt_load && !st_q.rate_loaded)
    begin
      st_d.rate_loaded = 1'b1;
      if (rate_opt_mhz == 6'h00)
        st_d.period = rate_period(6'(cfg_pkg::DEFAULT_RATE_MHZ));
      else if ((rate_opt_mhz <= 6'(cfg_pkg::MAX_RATE_MHZ)) &&
               (rate_period(rate_opt_mhz) < st_q.period))
        st_d.period = rate_period(rate_opt_mhz);
    end
    if ((st_q.mode == cfg_pkg::MODE_MASTER) && st_q.init_done && room)
    begin
      if (ms_rise)
        st_d.div_cnt = '0;
      else
        st_d.div_cnt = st_q.div_cnt + 1'b1;
      // Rises only at the wrap; a stray edge would shift the PROM early
      st_d.cfg_clock = ms_rise || (st_q.cfg_clock && (st_d.div_cnt < (st_q.period >> 1)));
    end

    // ==========================================================
    // Master serial shifting and chain forwarding
    if (ms_rise)
    begin
      if (st_q.done)
        st_d.dout = din_s;
      else
      begin
        st_d.shreg   = {st_q.shreg[6:0], din_s};
        st_d.bit_cnt = st_q.bit_cnt + 3'h1;
        if (st_q.bit_cnt == 3'h7)
        begin
          st_d.push      = 1'b1;
          st_d.push_data = {st_q.shreg[6:0], din_s};
        end
      end
    end

    // ==========================================================
    // Scan loading; cannot stall, so a full FIFO drops the byte
    if (tck_rise && instr_s && sdr_s)
    begin
      st_d.shreg   = {st_q.shreg[6:0], tdi_s};
      st_d.bit_cnt = st_q.bit_cnt + 3'h1;
      if (st_q.bit_cnt == 3'h7)
      begin
        st_d.push      = room;
        st_d.push_data = {st_q.shreg[6:0], tdi_s};
      end
    end

    // ==========================================================
    // Byte port, inputs taken on the link rising edge; select release is seen at any cycle
    if (link_rise && port_en)
    begin
      if (st_q.abort_cnt != 3'h0)
        st_d.abort_cnt = st_q.abort_cnt - 3'h1;
      if (cs_act && st_q.cs_prev && (wr_act != st_q.wr_prev))
      begin
        st_d.abort_cnt = 3'(cfg_pkg::ABORT_EDGES);
        st_d.aligned   = 1'b0;
      end
      else if (cs_act && wr_act && !st_q.busy && room)
      begin
        st_d.sync_sh = {st_q.sync_sh[23:0], bitrev(data_s)};
        if (st_q.aligned)
        begin
          st_d.push      = 1'b1;
          st_d.push_data = bitrev(data_s);
        end
        else if ({st_q.sync_sh[23:0], bitrev(data_s)} == SYNC_WORD)
          st_d.aligned = 1'b1;
      end
      else if (cs_act && !wr_act && rb_valid && st_q.abort_cnt == 3'h0)
      begin
        st_d.rd      = bitrev(rb_data);
        st_d.rb_take = 1'b1;
      end
      st_d.cs_prev = cs_act;
      st_d.wr_prev = wr_act;
    end
    if (port_en && !cs_act)
      st_d.cs_prev = 1'b0;

    // Busy only reflects a stalled sink or a running abort
    st_d.busy = port_en && ((st_d.abort_cnt != 3'h0) || !fifo_in_ready);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q         <= '0;
      st_q.period  <= 4'(cfg_pkg::BOOT_PERIOD);
      st_q.aligned <= 1'b1;
      st_q.mode    <= cfg_pkg::MODE_SLAVE;
    end
    else
      st_q <= st_d;
  end

  // ==========================================================
  // Buffer towards the internal configuration bus
  cfg_fifo #(
    .W     (8),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .arst_n    (arst_n),
    .in_valid  (st_q.push),
    .in_ready  (fifo_in_ready),
    .in_data   (st_q.push_data),
    .out_valid (cfg_bus_valid),
    .out_ready (cfg_bus_ready),
    .out_data  (cfg_bus_data)
  );

  // ==========================================================
  // Outputs
  assign dout           = st_q.dout;
  assign cfg_clock_o    = st_q.cfg_clock;
  assign cfg_clock_oe_n = !(st_q.mode == cfg_pkg::MODE_MASTER);
  assign data_o         = st_q.rd;
  assign data_oe_n      = !(port_en && cs_act && !wr_act);
  assign busy           = st_q.busy;
  assign rb_ready       = st_q.rb_take;
  assign init_done      = st_q.init_done;
  assign cfg_done       = st_q.done;

  // ==========================================================
  // Checks
  sequence abort_seen_s;
    link_rise && port_en && cs_act && st_q.cs_prev && (wr_act != st_q.wr_prev);
  endsequence

  sequence busy_held_s;
    st_q.busy [*4];
  endsequence

  serial_sample_a: assert property (@(posedge clk) disable iff (!arst_n)
    ms_rise && !st_q.done |=> st_q.shreg[0] == $past(din_s))
    else $error("serial bit not sampled on generated edge");
  chain_fwd_a: assert property (@(posedge clk) disable iff (!arst_n)
    ms_rise && st_q.done |=> st_q.dout == $past(din_s))
    else $error("chain output not updated");
  rate_only_up_a: assert property (@(posedge clk) disable iff (!arst_n)
    st_q.period <= $past(st_q.period))
    else $error("generated clock slowed down");
  boot_rate_a: assert property (@(posedge clk) disable iff (!arst_n)
    !st_q.rate_loaded |-> st_q.period == 4'(cfg_pkg::BOOT_PERIOD))
    else $error("boot rate wrong before option load");
  rate_cap_a: assert property (@(posedge clk) disable iff (!arst_n)
    rate_opt_load && !st_q.rate_loaded && rate_opt_mhz > 6'(cfg_pkg::MAX_RATE_MHZ) && rate_opt_mhz != 6'h00
    |=> st_q.period == $past(st_q.period))
    else $error("rate above cap accepted");
  scan_only_a: assert property (@(posedge clk) disable iff (!arst_n)
    st_q.mode == cfg_pkg::MODE_SCAN |-> data_oe_n && !busy && cfg_clock_oe_n)
    else $error("other port active in scan mode");
  abort_busy_a: assert property (@(posedge clk) disable iff (!arst_n)
    abort_seen_s |=> busy_held_s)
    else $error("busy not held during abort");
  unaligned_drop_a: assert property (@(posedge clk) disable iff (!arst_n)
    link_rise && port_en && !st_q.aligned && !instr_s && st_q.mode == cfg_pkg::MODE_BYTE |=> !st_q.push)
    else $error("byte pushed while unaligned");
  readback_byte_a: assert property (@(posedge clk) disable iff (!arst_n)
    st_q.rb_take |-> data_o == bitrev($past(rb_data)))
    else $error("readback byte not presented");

endmodule
`default_nettype wire

//--- bench/cfg_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Host on the byte port and serial PROM on din
module cfg_host_model (
  input  wire logic       clk,
  input  wire logic       busy,
  input  wire logic       cfg_clock_o,
  output logic            cfg_clock_i,
  output logic            cs_n,
  output logic            write_n,
  output logic      [7:0] data_i,
  output logic            din
);
  logic [31:0] prom_q = 32'h0;
  logic        orise_q = 1'b0;
  int          stalls = 0;

  initial
  begin
    cfg_clock_i = 1'b0;
    cs_n        = 1'b1;
    write_n     = 1'b1;
    data_i      = 8'h00;
    din         = 1'b0;
  end

  // ==========================================================
  // Link clock pulsed per task call, also with select released, 8 system cycles a period
  task automatic edge_pulse(output logic took);
    repeat (4) @(posedge clk);
    cfg_clock_i <= 1'b1;
    // Busy judged where the loader takes the edge, behind its synchroniser
    repeat (3) @(posedge clk);
    took = (busy === 1'b0);
    @(posedge clk);
    cfg_clock_i <= 1'b0;
  endtask

  // Byte held and re-clocked while busy, never dropped
  task automatic put_byte(input logic [7:0] b);
    logic took;
    cs_n    <= 1'b0;
    write_n <= 1'b0;
    data_i  <= b;
    took = 1'b0;
    while (!took)
    begin
      edge_pulse(took);
      if (!took)
        stalls++;
    end
  endtask

  // Released lines show the inverse so stale data cannot pass
  task automatic release_bus();
    @(posedge clk);
    cs_n    <= 1'b1;
    write_n <= 1'b1;
    data_i  <= ~data_i;
    @(posedge clk);
  endtask

  task automatic read_edge();
    logic t;
    @(posedge clk);
    cs_n    <= 1'b0;
    write_n <= 1'b1;
    edge_pulse(t);
  endtask

  // Deliberate strobe change under select
  task automatic flip_strobe();
    logic t;
    @(posedge clk);
    write_n <= ~write_n;
    edge_pulse(t);
  endtask

  task automatic load_prom(input logic [31:0] w);
    @(posedge clk);
    // Stay clear of the edge at which the PROM shifts itself
    while (cfg_clock_o === 1'b1 && orise_q === 1'b0)
      @(posedge clk);
    prom_q <= w;
    din    <= w[31];
  endtask

  // PROM advances after each generated rising edge
  always @(posedge clk)
  begin
    orise_q <= cfg_clock_o;
    if (cfg_clock_o === 1'b1 && orise_q === 1'b0)
    begin
      prom_q <= {prom_q[30:0], 1'b0};
      din    <= prom_q[30];
    end
  end
endmodule
`default_nettype wire

//--- bench/config_port_loader_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module config_port_loader_tb_top;
  // ==========================================================
  // Signals
  typedef struct packed {logic [7:0] pin; logic [7:0] head;} row_s;
  typedef struct packed {logic [5:0] rate; logic [7:0] per;} rate_s;
  logic       clk = 1'b0;
  logic       arst_n = 1'b0;
  logic [2:0] mode_pins = 3'b110;
  logic       jtag_tck = 1'b0;
  logic       jtag_tdi = 1'b0;
  logic       jtag_shift_dr = 1'b0;
  logic       cfg_load_instr = 1'b0;
  logic [5:0] rate_opt_mhz = 6'h00;
  logic       rate_opt_load = 1'b0;
  logic       retain_port = 1'b0;
  logic       load_complete = 1'b0;
  logic [7:0] rb_data = 8'h00;
  logic       rb_valid = 1'b0;
  logic       cfg_bus_ready = 1'b1;
  logic       dout, cfg_clock_i, cfg_clock_o, cfg_clock_oe_n, cs_n, write_n, din;
  logic [7:0] data_i, data_o, cfg_bus_data;
  logic       data_oe_n, busy, rb_ready, cfg_bus_valid, init_done, cfg_done;
  logic [7:0] got_q[$];
  logic [7:0] cnt_q = 8'h00;
  logic [7:0] per_q = 8'h00;
  logic       oclk_q = 1'b0;
  int         failures = 0;
  int         checked = 0;
  int         rb_seen = 0;
  int         cycles = 0;
  row_s  rows[6]  = '{'{8'h01, 8'h80}, '{8'h0F, 8'hF0}, '{8'h35, 8'hAC},
                      '{8'h12, 8'h48}, '{8'hFF, 8'hFF}, '{8'hC0, 8'h03}};
  rate_s rates[5] = '{'{6'h00, 8'h05}, '{6'h04, 8'h05}, '{6'h0A, 8'h02},
                      '{6'h3D, 8'h08}, '{6'h01, 8'h08}};

  always #25 clk = ~clk;

  config_port_loader uut (.clk(clk), .arst_n(arst_n), .mode_pins(mode_pins), .din(din), .dout(dout),
    .cfg_clock_i(cfg_clock_i), .cfg_clock_o(cfg_clock_o), .cfg_clock_oe_n(cfg_clock_oe_n), .cs_n(cs_n),
    .write_n(write_n), .data_i(data_i), .data_o(data_o), .data_oe_n(data_oe_n), .busy(busy),
    .jtag_tck(jtag_tck), .jtag_tdi(jtag_tdi), .jtag_shift_dr(jtag_shift_dr), .cfg_load_instr(cfg_load_instr),
    .rate_opt_mhz(rate_opt_mhz), .rate_opt_load(rate_opt_load), .retain_port(retain_port),
    .load_complete(load_complete), .rb_data(rb_data), .rb_valid(rb_valid), .rb_ready(rb_ready),
    .cfg_bus_data(cfg_bus_data), .cfg_bus_valid(cfg_bus_valid), .cfg_bus_ready(cfg_bus_ready),
    .init_done(init_done), .cfg_done(cfg_done));

  cfg_host_model host (.clk(clk), .busy(busy), .cfg_clock_o(cfg_clock_o), .cfg_clock_i(cfg_clock_i),
    .cs_n(cs_n), .write_n(write_n), .data_i(data_i), .din(din));

  // ==========================================================
  // Monitors and helpers
  always @(posedge clk)
  begin
    if (cfg_bus_valid === 1'b1 && cfg_bus_ready === 1'b1)
      got_q.push_back(cfg_bus_data);
    if (rb_ready === 1'b1)
      rb_seen++;
    oclk_q <= cfg_clock_o;
    cnt_q  <= (cfg_clock_o && !oclk_q) ? 8'h01 : cnt_q + 8'h01;
    if (cfg_clock_o && !oclk_q)
      per_q <= cnt_q;
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      final_report();
    end
  end

  function automatic logic [7:0] rev8(input logic [7:0] b);
    return {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Mode pins settle well before release
  task automatic do_reset(input logic [2:0] m);
    arst_n    <= 1'b0;
    mode_pins <= m;
    repeat (10) @(posedge clk);
    got_q.delete();
    arst_n <= 1'b1;
    repeat (20) @(posedge clk);
    check({7'h0, init_done}, 8'h01);
  endtask

  task automatic wait_got(input int n);
    for (int k = 0; k < 2000 && got_q.size() < n; k++)
      @(posedge clk);
  endtask

  task automatic scan_byte(input logic [7:0] b);
    jtag_shift_dr  <= 1'b1;
    cfg_load_instr <= 1'b1;
    for (int i = 7; i >= 0; i--)
    begin
      jtag_tdi <= b[i];
      repeat (4) @(posedge clk);
      jtag_tck <= 1'b1;
      repeat (4) @(posedge clk);
      jtag_tck <= 1'b0;
    end
    jtag_shift_dr  <= 1'b0;
    cfg_load_instr <= 1'b0;
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    logic        t;
    logic [47:0] seq;
    seq = {8'h22, cfg_pkg::SYNC_WORD, 8'h33};
    do_reset(3'b110);
    for (int i = 0; i < 6; i++)
    begin
      if (i == 3)
        host.release_bus();
      host.put_byte(rows[i].pin);
    end
    host.release_bus();
    wait_got(6);
    foreach (rows[i])
      check(got_q[i], rows[i].head);
    check(8'(host.stalls), 8'h00);
    $display("byte rows done");
    // Sink stalls until the buffer refuses
    got_q.delete();
    cfg_bus_ready <= 1'b0;
    fork
      for (int k = 0; k < 20; k++)
        host.put_byte(8'h40 + 8'(k));
      begin
        repeat (300) @(posedge clk);
        cfg_bus_ready <= 1'b1;
      end
    join
    host.release_bus();
    wait_got(20);
    for (int k = 0; k < 20; k++)
      check(got_q[k], rev8(8'h40 + 8'(k)));
    check({7'h0, host.stalls > 0}, 8'h01);
    $display("buffer fill done");
    // Abort, then unaligned data until the sync word
    got_q.delete();
    host.put_byte(8'h01);
    host.flip_strobe();
    repeat (2) @(negedge clk);
    check({7'h0, busy}, 8'h01);
    host.release_bus();
    for (int k = 0; k < 10 && busy !== 1'b0; k++)
      host.edge_pulse(t);
    check({7'h0, busy}, 8'h00);
    for (int k = 0; k < 6; k++)
      host.put_byte(rev8(seq[47 - 8 * k -: 8]));
    host.release_bus();
    wait_got(2);
    repeat (20) @(posedge clk);
    check(8'(got_q.size()), 8'h02);
    check(got_q[0], 8'h80);
    check(got_q[1], 8'h33);
    got_q.delete();
    scan_byte(8'h5A);
    wait_got(1);
    check(got_q[0], 8'h5A);
    $display("abort and scan done");
    // Readback, then release of the port
    rb_data  <= 8'h96;
    rb_valid <= 1'b1;
    host.read_edge();
    @(negedge clk);
    check({7'h0, data_oe_n}, 8'h00);
    check(data_o, 8'h69);
    check(8'(rb_seen), 8'h01);
    host.release_bus();
    load_complete <= 1'b1;
    repeat (4) @(posedge clk);
    check({7'h0, cfg_done}, 8'h01);
    host.read_edge();
    @(negedge clk);
    check({7'h0, data_oe_n}, 8'h01);
    @(posedge clk);
    retain_port <= 1'b1;
    @(negedge clk);
    check({7'h0, data_oe_n}, 8'h00);
    host.release_bus();
    retain_port   <= 1'b0;
    load_complete <= 1'b0;
    $display("readback done");
    // Generated clock rates in master serial
    foreach (rates[i])
    begin
      host.load_prom(32'hB4E1_0F5A);
      do_reset(3'b100);
      repeat (40) @(posedge clk);
      check(per_q, 8'h08);
      check({7'h0, cfg_clock_oe_n}, 8'h00);
      wait_got(1);
      check(got_q[0], 8'hB4);
      rate_opt_mhz  <= rates[i].rate;
      rate_opt_load <= 1'b1;
      @(posedge clk);
      rate_opt_load <= 1'b0;
      repeat (40) @(posedge clk);
      check(per_q, rates[i].per);
    end
    load_complete <= 1'b1;
    host.load_prom(32'hFFFF_FFFF);
    repeat (40) @(posedge clk);
    check({7'h0, dout}, 8'h01);
    host.load_prom(32'h0000_0000);
    repeat (40) @(posedge clk);
    check({7'h0, dout}, 8'h00);
    load_complete <= 1'b0;
    $display("master rates done");
    do_reset(3'b101);
    host.read_edge();
    @(negedge clk);
    check({6'h0, data_oe_n, cfg_clock_oe_n}, 8'h03);
    host.release_bus();
    $display("scan mode done");
    final_report();
  end
endmodule
`default_nettype wire
